/* eotw_pkg.sv */
// constants and types shared by the engine-off wake timer
package eotw_pkg;
    localparam int EOTW_CLK_HZ = 125000000;
    localparam int EOTW_OSC_HZ = 32768;
    localparam int EOTW_SLOW_HZ = 1;
    // 125 MHz / 32768 Hz, rounded down
    localparam int EOTW_OSC_DIV = EOTW_CLK_HZ / EOTW_OSC_HZ;
    localparam int EOTW_SLOW_DIV = EOTW_OSC_HZ / EOTW_SLOW_HZ;
    localparam int EOTW_UP_W = 24;
    localparam int EOTW_DN_W = 6;
    localparam logic [23:0] EOTW_UP_RESET = 24'h000000;
    localparam logic [23:0] EOTW_UP_MAX = 24'hFFFFFF;
    localparam logic [5:0] EOTW_DN_MAX = 6'h3F;
    localparam logic [5:0] EOTW_DN_MIN = 6'h00;
    localparam logic [1:0] EOTW_OVR_PIN = 2'h0;
    localparam logic [1:0] EOTW_OVR_LOW = 2'h2;
    localparam logic [1:0] EOTW_OVR_HIGH = 2'h3;
    localparam logic [1:0] EOTW_ACT_NONE = 2'h0;
    localparam logic [1:0] EOTW_ACT_DEEP = 2'h1;
    localparam logic [1:0] EOTW_ACT_TONLY = 2'h3;

    typedef enum logic [3:0] {
        EOTW_ST_ACTIVE = 4'h1,
        EOTW_ST_DEEP = 4'h2,
        EOTW_ST_TONLY = 4'h4,
        EOTW_ST_OFF = 4'h8
    } eotw_state_type;
endpackage

/* eotw_tick_gen.sv */
// tick divider: oscillator-rate and counting-rate enables
`timescale 1ns/1ps
`default_nettype none
module eotw_tick_gen #(
    parameter int OSC_DIV = 3814,
    parameter int SLOW_DIV = 32768
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic fast_mode,
    // ticks
    output logic count_tick
);
    logic [15:0] osc_cnt_reg;
    logic [15:0] slow_cnt_reg;
    logic osc_tick;

    assign osc_tick = (osc_cnt_reg == 16'(OSC_DIV - 1));

    // free-running oscillator, never gated
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_cnt_reg <= 16'h0000;
        end else if (osc_tick) begin
            osc_cnt_reg <= 16'h0000;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_cnt_reg <= 16'h0000;
        end else if (osc_tick) begin
            if (slow_cnt_reg == 16'(SLOW_DIV - 1)) begin
                slow_cnt_reg <= 16'h0000;
            end else begin
                slow_cnt_reg <= slow_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_tick <= 1'b0;
        end else begin
            count_tick <= osc_tick &
                (fast_mode | (slow_cnt_reg == 16'(SLOW_DIV - 1)));
        end
    end
endmodule
`default_nettype wire

/* eotw_timer.sv */
// engine-off wake timer: counters, alarms and power-state requests
// Functional notes
// R01 - 24-bit up and 6-bit down counters
// R02 - count at 1 Hz or fast 32768 Hz
// R03 - host access in all but off state
// R04 - clear up-counter, saturate at all-ones
// R05 - overflow alarm at all-ones
// R06 - wake alarm when count reaches compare value
// R07 - pause holds the up-counter
// R08 - load down-counter, saturate at zero
// R09 - zero alarm when down-counter hits zero
// R10 - pause holds the down-counter
// R11 - runs while wake inputs low
// R12 - alarms drive interrupt; only the wake alarm drives state requests
// R13 - alarm flags sticky until host clear
// R14 - host writes compare bytes before enable
// R15 - wake action selects which state exits
// R16 - counting begins when enable written
// R17 - deep halt from request pin or override
// R18 - timer-only from wake inputs or overrides
// R19 - host restores inputs then clears action
// R20 - host clears flag, enable, then run
// R21 - host writes cross without count loss
`timescale 1ns/1ps
`default_nettype none
module eotw_timer
    import eotw_pkg::*;
#(
    parameter int OSC_DIV = eotw_pkg::EOTW_OSC_DIV,
    parameter int SLOW_DIV = eotw_pkg::EOTW_SLOW_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host writes, one-cycle strobes with data
    input wire logic host_off,
    input wire logic up_clear,
    input wire logic dn_load,
    input wire logic [5:0] dn_load_value,
    input wire logic wake_time_byte0_we,
    input wire logic wake_time_byte1_we,
    input wire logic wake_time_byte2_we,
    input wire logic [7:0] wake_byte_data,
    input wire logic [3:0] flag_clear,
    // host control levels
    input wire logic timer_run_enable,
    input wire logic wake_alarm_enable,
    input wire logic fast_mode,
    input wire logic up_pause,
    input wire logic dn_pause,
    input wire logic zero_alarm_enable,
    input wire logic [2:0] alarm_int_enable,
    input wire logic [1:0] wake_action_select,
    input wire logic [1:0] low_power_request_override,
    input wire logic [1:0] wake_input_1_override,
    input wire logic [1:0] wake_input_2_override,
    // pins
    input wire logic low_power_request_n,
    input wire logic wake_input_1,
    input wire logic wake_input_2,
    // status
    output logic [23:0] up_count,
    output logic [5:0] dn_count,
    output logic [23:0] wake_compare,
    output logic overflow_flag,
    output logic wake_alarm_flag,
    output logic zero_flag,
    output logic host_access_ok,
    output logic interrupt_out_n,
    output eotw_pkg::eotw_state_type power_state
);
    import eotw_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic count_tick;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic lpr_level;
    logic wake_input_1_level;
    logic wake_input_2_level;
    logic running;
    logic wake_hit;
    logic deep_wake;
    logic tonly_wake;
    logic [2:0] clear_taken;
    logic [23:0] up_next;
    logic [5:0] dn_next;
    eotw_state_type state_next;

    function automatic logic ovr_level(input logic [1:0] ovr,
                                       input logic pin);
        ovr_level = (ovr == EOTW_OVR_LOW) ? 1'b0 :
                    (ovr == EOTW_OVR_HIGH) ? 1'b1 : pin;
    endfunction

    eotw_tick_gen #(
        .OSC_DIV(OSC_DIV),
        .SLOW_DIV(SLOW_DIV)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .fast_mode(fast_mode), // R02
        .count_tick(count_tick)
    );

    // pin synchronisers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= 3'h7;
            pin_s2_reg <= 3'h7;
        end else begin
            pin_s1_reg <= {wake_input_2, wake_input_1, low_power_request_n};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign lpr_level = ovr_level(low_power_request_override,
                                 pin_s2_reg[0]); // R17
    assign wake_input_1_level = ovr_level(wake_input_1_override,
                                   pin_s2_reg[1]); // R18
    assign wake_input_2_level = ovr_level(wake_input_2_override,
                                   pin_s2_reg[2]); // R18

    // host side is in the same clock, so strobes act directly
    assign clear_taken = flag_clear[2:0] & {3{host_access_ok}}; // R03
    // wake levels do not gate the count
    assign running = timer_run_enable; // R11 R16
    // an alarm wake keeps the device out of the state its wake action selects until the host re-arms
    assign deep_wake = (wake_action_select == EOTW_ACT_DEEP) &&
                       wake_alarm_flag;
    assign tonly_wake = (wake_action_select == EOTW_ACT_TONLY) &&
                        wake_alarm_flag;

    always_comb begin
        up_next = up_count;
        if (up_clear && host_access_ok) begin
            up_next = EOTW_UP_RESET; // R04
        end else if (running && count_tick && !up_pause &&
                     up_count != EOTW_UP_MAX) begin // R07
            up_next = up_count + 24'h000001; // R01 R04
        end
    end

    always_comb begin
        dn_next = dn_count;
        if (dn_load && host_access_ok) begin
            dn_next = dn_load_value; // R08
        end else if (running && count_tick && !dn_pause &&
                     dn_count != EOTW_DN_MIN) begin // R10
            dn_next = dn_count - 6'h01; // R01 R08
        end
    end

    // load wins over count in the same cycle, no double count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up_count <= EOTW_UP_RESET;
            dn_count <= EOTW_DN_MIN;
        end else begin // R11 R21
            up_count <= up_next;
            dn_count <= dn_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_compare <= 24'h000000;
        end else if (host_access_ok) begin
            if (wake_time_byte0_we) begin
                wake_compare[7:0] <= wake_byte_data; // R14
            end
            if (wake_time_byte1_we) begin
                wake_compare[15:8] <= wake_byte_data;
            end
            if (wake_time_byte2_we) begin
                wake_compare[23:16] <= wake_byte_data;
            end
        end
    end

    assign wake_hit = running && wake_alarm_enable &&
                      (up_count >= wake_compare); // R06

    // sticky flags, set beats clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
            wake_alarm_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else begin
            overflow_flag <= (up_count == EOTW_UP_MAX) |
                (overflow_flag & ~clear_taken[0]); // R05 R13
            wake_alarm_flag <= wake_hit |
                (wake_alarm_flag & ~clear_taken[1]); // R06 R13
            zero_flag <= (running && zero_alarm_enable &&
                dn_count == EOTW_DN_MIN) |
                (zero_flag & ~clear_taken[2]); // R09 R13
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~|({zero_flag, wake_alarm_flag,
                overflow_flag} & alarm_int_enable); // R12
        end
    end

    always_comb begin
        state_next = power_state;
        unique case (power_state)
            EOTW_ST_ACTIVE: begin
                if (host_off) begin
                    state_next = EOTW_ST_OFF;
                end else if (!lpr_level && !deep_wake) begin
                    state_next = EOTW_ST_DEEP; // R17
                end else if (!wake_input_1_level && !wake_input_2_level &&
                             !tonly_wake) begin
                    state_next = EOTW_ST_TONLY; // R18
                end
            end
            EOTW_ST_DEEP: begin
                if (deep_wake) begin
                    state_next = EOTW_ST_ACTIVE; // R15 R12
                end else if (wake_action_select == EOTW_ACT_NONE &&
                             lpr_level) begin
                    state_next = EOTW_ST_ACTIVE; // R15
                end
            end
            EOTW_ST_TONLY: begin
                if (tonly_wake) begin
                    state_next = EOTW_ST_ACTIVE; // R15 R12
                end else if (wake_action_select == EOTW_ACT_NONE &&
                             (wake_input_1_level || wake_input_2_level)) begin
                    state_next = EOTW_ST_ACTIVE; // R15
                end
            end
            EOTW_ST_OFF: begin
                if (wake_input_1_level || wake_input_2_level) begin
                    state_next = EOTW_ST_ACTIVE;
                end
            end
            default: begin
                state_next = EOTW_ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_state <= EOTW_ST_ACTIVE;
            host_access_ok <= 1'b1;
        end else begin
            power_state <= state_next;
            host_access_ok <= (state_next != EOTW_ST_OFF); // R03
        end
    end

    AST_UP_SATURATES: assert property ( // R04
        (up_count == EOTW_UP_MAX && !up_clear) |=> up_count == EOTW_UP_MAX)
        else $error("up counter wrapped");
    AST_UP_CLEAR: assert property ( // R04
        (up_clear && host_access_ok) |=> up_count == EOTW_UP_RESET)
        else $error("up counter not cleared");
    AST_UP_COUNTS: assert property ( // R01 R11
        (running && count_tick && !up_pause && !up_clear &&
         up_count != EOTW_UP_MAX)
        |=> up_count == $past(up_count) + 24'h000001)
        else $error("up counter missed a tick");
    AST_UP_PAUSE: assert property ( // R07
        (up_pause && !up_clear) |=> $stable(up_count))
        else $error("paused up counter moved");
    AST_DN_SATURATES: assert property ( // R08
        (dn_count == EOTW_DN_MIN && !dn_load) |=> dn_count == EOTW_DN_MIN)
        else $error("down counter wrapped");
    AST_DN_LOAD: assert property ( // R08
        (dn_load && host_access_ok) |=> dn_count == $past(dn_load_value))
        else $error("down counter not loaded");
    AST_DN_COUNTS: assert property ( // R01 R08
        (running && count_tick && !dn_pause && !dn_load &&
         dn_count != EOTW_DN_MIN)
        |=> dn_count == $past(dn_count) - 6'h01)
        else $error("down counter missed a tick");
    AST_DN_PAUSE: assert property ( // R10
        (dn_pause && !dn_load) |=> $stable(dn_count))
        else $error("paused down counter moved");
    AST_OFF_REFUSED: assert property ( // R03
        !host_access_ok |=> $stable(wake_compare))
        else $error("compare written while off");
    AST_OVF_FLAG: assert property ( // R05
        up_count == EOTW_UP_MAX |=> overflow_flag)
        else $error("overflow not flagged");
    AST_WAKE_FLAG: assert property ( // R06
        (running && wake_alarm_enable && up_count >= wake_compare)
        |=> wake_alarm_flag)
        else $error("wake alarm missed");
    AST_ZERO_FLAG: assert property ( // R09
        (running && zero_alarm_enable && dn_count == EOTW_DN_MIN)
        |=> zero_flag)
        else $error("zero alarm missed");
    sequence s_flag_held;
        wake_alarm_flag && !flag_clear[1];
    endsequence
    AST_FLAG_STICKY: assert property ( // R13
        s_flag_held |=> wake_alarm_flag)
        else $error("wake flag lost");
    AST_INT_PIN: assert property ( // R12
        (wake_alarm_flag && alarm_int_enable[1]) |=> !interrupt_out_n)
        else $error("interrupt not driven");
    sequence s_deep_alarm;
        power_state == EOTW_ST_DEEP && deep_wake;
    endsequence
    AST_DEEP_WAKE: assert property ( // R15
        s_deep_alarm |=> power_state == EOTW_ST_ACTIVE)
        else $error("deep halt wake failed");
    sequence s_tonly_alarm;
        power_state == EOTW_ST_TONLY && tonly_wake;
    endsequence
    AST_TONLY_WAKE: assert property ( // R15
        s_tonly_alarm |=> power_state == EOTW_ST_ACTIVE)
        else $error("timer-only wake failed");
    AST_HOLD_ACTIVE: assert property ( // R15
        (power_state == EOTW_ST_ACTIVE && deep_wake)
        |=> power_state != EOTW_ST_DEEP)
        else $error("fell back into deep halt");
endmodule
`default_nettype wire

/* eotw_pin_model.sv */
// far-side pin model: power-request and wake pins
`timescale 1ns/1ps
`default_nettype none
module eotw_pin_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic lp_req,
    input wire logic sleep_req,
    // pins
    output logic low_power_request_n,
    output logic wake_input_1,
    output logic wake_input_2
);
    initial begin
        low_power_request_n = 1'b1;
        wake_input_1 = 1'b1;
        wake_input_2 = 1'b1;
    end
    // pins move just after the edge, like a real driver
    always @(posedge clk) begin
        low_power_request_n <= #1 !lp_req;
        wake_input_1 <= #1 !sleep_req;
        wake_input_2 <= #1 !sleep_req;
    end
endmodule
`default_nettype wire

/* eotw_timer_test.sv */
// self-checking bench for the engine-off wake timer
`timescale 1ns/1ps
`default_nettype none
module eotw_timer_test;
    import eotw_pkg::*;
    typedef struct {string name; int sel; logic [23:0] exp;} eotw_note_type;
    logic clk = 0, rst_b = 0, host_off = 0, up_clear = 0, dn_load = 0;
    logic we0 = 0, we1 = 0, we2 = 0, run = 0, wen = 0, fast = 0;
    logic up_pause = 0, dn_pause = 0, zen = 0, lp_req = 0, sleep_req = 0;
    logic chk_req = 0;
    logic [5:0] dn_load_value = 0;
    logic [7:0] wake_byte_data = 0;
    logic [3:0] flag_clear = 0;
    logic [2:0] ien = 0;
    logic [1:0] act = 0, lp_ovr = 0, w1_ovr = 0, w2_ovr = 0;
    logic lp_n, w1, w2, ovf, wflag, zflag, ok, int_n;
    logic [23:0] up_count, wake_compare;
    logic [5:0] dn_count;
    logic [7:0] d [3];
    eotw_state_type st;
    eotw_note_type notes [$];
    int n_errors = 0, checks_done = 0, seed = 66024, i, k;

    always #4 clk = ~clk;

    eotw_timer #(.OSC_DIV(4), .SLOW_DIV(4)) u_eotw_timer (
        .clk(clk), .rst_b(rst_b), .host_off(host_off), .up_clear(up_clear),
        .dn_load(dn_load), .dn_load_value(dn_load_value),
        .wake_time_byte0_we(we0), .wake_time_byte1_we(we1),
        .wake_time_byte2_we(we2), .wake_byte_data(wake_byte_data),
        .flag_clear(flag_clear), .timer_run_enable(run),
        .wake_alarm_enable(wen), .fast_mode(fast), .up_pause(up_pause),
        .dn_pause(dn_pause), .zero_alarm_enable(zen),
        .alarm_int_enable(ien), .wake_action_select(act),
        .low_power_request_override(lp_ovr),
        .wake_input_1_override(w1_ovr), .wake_input_2_override(w2_ovr),
        .low_power_request_n(lp_n), .wake_input_1(w1), .wake_input_2(w2),
        .up_count(up_count), .dn_count(dn_count),
        .wake_compare(wake_compare), .overflow_flag(ovf),
        .wake_alarm_flag(wflag), .zero_flag(zflag), .host_access_ok(ok),
        .interrupt_out_n(int_n), .power_state(st)
    );

    eotw_pin_model u_eotw_pin_model (
        .clk(clk), .lp_req(lp_req), .sleep_req(sleep_req),
        .low_power_request_n(lp_n), .wake_input_1(w1), .wake_input_2(w2)
    );

    task summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task cmp_val(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task cmp_bits(input string nm, input logic [3:0] e, input logic [3:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // expectation goes to the queue; the watcher compares at falling edge
    task note(input string nm, input int sel, input logic [23:0] e);
        eotw_note_type n;
        n.name = nm;
        n.sel = sel;
        n.exp = e;
        notes.push_back(n);
        chk_req = 1;
        @(negedge clk);
        #1 chk_req = 0;
        step(1);
    endtask

    task wr(input int b, input logic [7:0] v);
        wake_byte_data = v;
        we0 = (b == 0);
        we1 = (b == 1);
        we2 = (b == 2);
        step(1);
        {we0, we1, we2} = 3'h0;
        step(1);
    endtask

    task wait_wake;
        for (k = 0; k < 400 && wflag !== 1'b1; k++)
            step(1);
    endtask

    always @(negedge clk) begin
        if (chk_req && notes.size() > 0) begin : watch
            eotw_note_type n;
            n = notes.pop_front();
            case (n.sel)
                0: cmp_val(n.name, n.exp, up_count);
                1: cmp_val(n.name, n.exp, {18'h0, dn_count});
                2: cmp_val(n.name, n.exp, wake_compare);
                3: cmp_bits(n.name, n.exp[3:0], {ovf, wflag, zflag, int_n});
                4: cmp_bits(n.name, n.exp[3:0], st);
                6: cmp_bits(n.name, n.exp[3:0], {3'h0, ok});
                default: cmp_bits(n.name, n.exp[3:0],
                    {1'b0, up_count > 24'h2, up_count < 24'h8,
                     up_count < 24'h10});
            endcase
        end
    end

    initial begin
        #(20000 * 8);
        n_errors++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1 rst_b = 1;
        step(1);
        note("up_count", 0, 24'h0);
        note("flags", 3, 24'h1);
        note("state", 4, EOTW_ST_ACTIVE);
        for (i = 0; i < 3; i++) begin
            d[i] = 8'($random(seed));
            wr(i, d[i]);
        end
        note("wake_compare", 2, {d[2], d[1], d[0]});
        wr(0, 8'h06);
        wr(1, 8'h00);
        wr(2, 8'h00);
        {up_pause, dn_pause, dn_load, up_clear} = 4'hF;
        dn_load_value = 6'h05;
        step(1);
        {dn_load, up_clear} = 2'h0;
        fast = 1;
        ien = 3'h2;
        wen = 1;
        step(1);
        run = 1;
        step(64);
        note("up_held", 0, 24'h0);
        note("dn_held", 1, 24'h5);
        {up_pause, dn_pause} = 2'h0;
        wait_wake();
        step(2);
        note("flags", 3, 24'h4);
        step(20);
        note("dn_floor", 1, 24'h0);
        zen = 1;
        ien = 3'h4;
        step(4);
        note("flags", 3, 24'h6);
        flag_clear = 4'h7;
        step(1);
        flag_clear = 0;
        {wen, zen} = 2'h0;
        step(1);
        run = 0;
        step(1);
        flag_clear = 4'h7;
        step(1);
        flag_clear = 0;
        step(2);
        note("flags", 3, 24'h1);
        dn_load_value = 6'h3F;
        {dn_load, up_clear} = 2'h3;
        step(1);
        {dn_load, up_clear} = 2'h0;
        note("dn_load", 1, 24'h3F);
        note("up_clear", 0, 24'h0);
        fast = 0;
        run = 1;
        step(64);
        note("slow_rate", 5, 24'h7);
        fast = 1;
        step(64);
        note("fast_rate", 5, 24'h4);
        run = 0;
        wr(0, 8'h10);
        for (i = 0; i < 3; i++) begin
            if (i == 0)
                act = EOTW_ACT_DEEP;
            else
                act = (i == 1) ? EOTW_ACT_TONLY : EOTW_ACT_NONE;
            up_clear = 1;
            step(1);
            up_clear = 0;
            wen = 1;
            step(1);
            run = 1;
            lp_ovr = (i == 0) ? EOTW_OVR_LOW : EOTW_OVR_PIN;
            lp_req = (i == 2);
            sleep_req = (i == 1);
            step(6);
            note("sleep", 4, (i == 1) ? EOTW_ST_TONLY : EOTW_ST_DEEP);
            wait_wake();
            step(3);
            note("woken", 4, (i == 2) ? EOTW_ST_DEEP : EOTW_ST_ACTIVE);
            lp_ovr = EOTW_OVR_HIGH;
            {lp_req, sleep_req} = 2'h0;
            step(3);
            act = EOTW_ACT_NONE;
            flag_clear = 4'h2;
            step(1);
            flag_clear = 0;
            wen = 0;
            step(1);
            run = 0;
            flag_clear = 4'h2;
            lp_ovr = EOTW_OVR_PIN;
            step(1);
            flag_clear = 0;
            step(3);
        end
        up_clear = 1;
        step(1);
        up_clear = 0;
        run = 1;
        {w1_ovr, w2_ovr} = 4'hA;
        host_off = 1;
        step(1);
        host_off = 0;
        up_clear = 1;
        wr(2, 8'hA5);
        step(40);
        note("off_count", 5, 24'h5);
        note("off_compare", 2, 24'h000010);
        note("off_state", 4, EOTW_ST_OFF);
        note("off_access", 6, 24'h0);
        up_clear = 0;
        {w1_ovr, w2_ovr} = 4'h0;
        step(2);
        note("on_state", 4, EOTW_ST_ACTIVE);
        note("on_access", 6, 24'h1);
        summarize();
    end
endmodule
`default_nettype wire
